// [verilog/frm_defs.svh]
`ifndef FRM_DEFS_SVH
`define FRM_DEFS_SVH

`define FRM_CLK_PERIOD_NS   10
`define FRM_ABORT_DELAY_NS  200
`define FRM_ABORT_CYCLES    ((`FRM_ABORT_DELAY_NS + `FRM_CLK_PERIOD_NS - 1) / `FRM_CLK_PERIOD_NS)
`define FRM_BAUD_DIV        868
`define FRM_ID_BYTES        7
`define FRM_FIFO_DEPTH      16
`define FRM_ACK_OK          8'h06
`define FRM_ACK_BAD         8'h15
`define FRM_SYNC_RESET      3'h7

`endif

// [verilog/frm_pkg.sv]
`default_nettype none
package frm_pkg;
    typedef enum logic [1:0] {
        MODE_CPU         = 2'b00,
        MODE_SER_ASYNC   = 2'b01,
        MODE_SER_SPECIAL = 2'b10,
        MODE_PARALLEL    = 2'b11
    } frm_mode_t;
    typedef enum logic [1:0] {
        OP_NONE  = 2'b00,
        OP_READ  = 2'b01,
        OP_PROG  = 2'b10,
        OP_ERASE = 2'b11
    } frm_op_t;
    typedef enum logic [1:0] {
        ENG_IDLE  = 2'b00,
        ENG_BUSY  = 2'b01,
        ENG_ABORT = 2'b10
    } frm_eng_t;
    typedef enum logic [1:0] {
        RX_IDLE  = 2'b00,
        RX_START = 2'b01,
        RX_DATA  = 2'b10,
        RX_STOP  = 2'b11
    } frm_rx_t;
endpackage : frm_pkg
`default_nettype wire

// [verilog/frm_fifo.sv]
`timescale 1ns/1ps
`default_nettype none
module frm_fifo #(
    parameter int W     = 8,
    parameter int DEPTH = 16
) (
    input  wire logic         clk_in,
    input  wire logic         reset_in,
    input  wire logic         in_valid_in,
    input  wire logic [W-1:0] in_data_in,
    output logic              in_ready_out,
    output logic              out_valid_out,
    output logic [W-1:0]      out_data_out,
    input  wire logic         out_ready_in
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = AW + 1;

    logic [W-1:0]  mem [DEPTH];
    logic [AW-1:0] wr_ptr_reg, wr_ptr_next, rd_ptr_reg, rd_ptr_next;
    logic [CW-1:0] cnt_reg, cnt_next;
    logic [W-1:0]  head_reg, head_next;
    logic          head_v_reg, head_v_next;
    logic          wr, load;

    // Head register gives registered read data; capacity is DEPTH plus the head
    always_comb begin
        in_ready_out = (cnt_reg != CW'(DEPTH));
        wr           = in_valid_in & in_ready_out;
        load         = (cnt_reg != '0) & (~head_v_reg | out_ready_in);
        wr_ptr_next  = wr ? wr_ptr_reg + AW'(1) : wr_ptr_reg;
        rd_ptr_next  = load ? rd_ptr_reg + AW'(1) : rd_ptr_reg;
        cnt_next     = cnt_reg + CW'(wr) - CW'(load);
        head_v_next  = load | (head_v_reg & ~out_ready_in);
        head_next    = load ? mem[rd_ptr_reg] : head_reg;
    end

    always_ff @(posedge clk_in) begin
        if (wr) begin
            mem[wr_ptr_reg] <= in_data_in;
        end
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            cnt_reg    <= '0;
            head_reg   <= '0;
            head_v_reg <= 1'b0;
        end else begin
            wr_ptr_reg <= wr_ptr_next;
            rd_ptr_reg <= rd_ptr_next;
            cnt_reg    <= cnt_next;
            head_reg   <= head_next;
            head_v_reg <= head_v_next;
        end
    end

    assign out_valid_out = head_v_reg;
    assign out_data_out  = head_reg;
endmodule : frm_fifo
`default_nettype wire

// [verilog/frm_ctrl.sv]
// What this block, its software and the board must do
// [RQ1] Serial access gated by ID code match
// [RQ2] Mode 2: separate transmit and receive lines
// [RQ3] Mode 3: mode pin is bidirectional data
// [RQ4] Parallel port commands drive flash operations
// [RQ5] Code protection refuses parallel read/rewrite
// [RQ6] Software keeps CPU clock low in RAM mode
// [RQ7] Software avoids flash-fetching trap instructions
// [RQ8] Maskable interrupts serviceable during RAM rewrite
// [RQ9] Watchdog/osc/voltage interrupt aborts, resets flash
// [RQ10] Interrupt starts after fixed delay, flash restarts
// [RQ11] Software re-erases after forced abort
// [RQ12] Software refreshes watchdog during commands
// [RQ13] Software disables address-match interrupt meanwhile
// [RQ14] Software blocks NMI during block 0 erase
// [RQ15] Only serial modes 2 and 3 supported
// [RQ16] Board drives mode pin high, resets after
// [RQ17] Abort delay is a parameter cycle count
`include "frm_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module frm_ctrl import frm_pkg::*; #(
    parameter int ADDR_W       = 16,
    parameter int ID_BYTES     = `FRM_ID_BYTES,
    parameter int BAUD_DIV     = `FRM_BAUD_DIV,
    parameter int ABORT_CYCLES = `FRM_ABORT_CYCLES
) (
    input  wire logic                  clk_in,
    input  wire logic                  reset_in,
    input  wire logic [1:0]            prog_mode_in,
    input  wire logic [8*ID_BYTES-1:0] stored_id_in,
    input  wire logic                  protect_active_in,
    input  wire logic                  rxd_in,
    output logic                       txd_out,
    input  wire logic                  mode_pin_in,
    output logic                       mode_pin_out,
    output logic                       mode_pin_oe_out,
    input  wire logic                  par_valid_in,
    input  wire logic [1:0]            par_op_in,
    input  wire logic [ADDR_W-1:0]     par_addr_in,
    input  wire logic [7:0]            par_data_in,
    output logic                       par_ready_out,
    input  wire logic                  cpu_valid_in,
    input  wire logic [1:0]            cpu_op_in,
    input  wire logic [ADDR_W-1:0]     cpu_addr_in,
    input  wire logic [7:0]            cpu_data_in,
    output logic                       cpu_ready_out,
    output logic                       rd_valid_out,
    output logic [7:0]                 rd_data_out,
    input  wire logic                  rd_ready_in,
    output logic                       id_ok_out,
    output logic                       refused_out,
    output logic                       flash_req_out,
    output logic [1:0]                 flash_op_out,
    output logic [ADDR_W-1:0]          flash_addr_out,
    output logic [7:0]                 flash_data_out,
    input  wire logic                  flash_done_in,
    input  wire logic [7:0]            flash_rdata_in,
    output logic                       flash_reset_out,
    input  wire logic                  ram_exec_rewrite_mode_in,
    input  wire logic                  wdt_ack_in,
    input  wire logic                  osc_stop_ack_in,
    input  wire logic                  volt_mon_ack_in,
    output logic                       irq_start_out,
    input  wire logic                  mask_irq_req_in,
    output logic                       mask_irq_grant_out
);
    localparam logic [15:0] BAUD_LAST  = 16'(BAUD_DIV - 1);
    localparam logic [15:0] HALF_LAST  = 16'(BAUD_DIV / 2 - 1);
    localparam logic [15:0] ABORT_LAST = 16'(ABORT_CYCLES - 1);
    localparam int          ABORT_WAIT = ABORT_CYCLES - 1;

    frm_mode_t mode;
    logic      ser_mode, special;
    assign mode     = frm_mode_t'(prog_mode_in);
    assign ser_mode = (mode == MODE_SER_ASYNC) | (mode == MODE_SER_SPECIAL); // RQ15
    assign special  = (mode == MODE_SER_SPECIAL);

    // Pin synchronisers: three stages, level changes when stages 2 and 3 agree
    logic [1:0] pin_raw, pin_f;
    assign pin_raw = {mode_pin_in, rxd_in};
    genvar g;
    for (g = 0; g < 2; g++) begin : g_sync
        logic [2:0] s_reg, s_next;
        logic       f_reg, f_next;
        always_comb begin
            s_next = {s_reg[1:0], pin_raw[g]};
            f_next = (s_reg[1] == s_reg[2]) ? s_reg[2] : f_reg;
        end
        always_ff @(posedge clk_in) begin
            if (reset_in) begin
                s_reg <= `FRM_SYNC_RESET;
                f_reg <= 1'b1;
            end else begin
                s_reg <= s_next;
                f_reg <= f_next;
            end
        end
        assign pin_f[g] = f_reg;
    end

    // UART receiver
    frm_rx_t     rx_state_reg, rx_state_next;
    logic [15:0] rx_cnt_reg, rx_cnt_next;
    logic [2:0]  rx_bit_reg, rx_bit_next;
    logic [7:0]  rx_sh_reg, rx_sh_next;
    logic        rx_done_reg, rx_done_next;
    logic        tx_act_reg;
    logic        rx_line;
    // Half-duplex on the mode pin: own transmission must not echo back
    assign rx_line = special ? (pin_f[1] | tx_act_reg) : pin_f[0]; // RQ2 RQ3

    always_comb begin
        rx_state_next = rx_state_reg;
        rx_cnt_next   = rx_cnt_reg + 16'h0001;
        rx_bit_next   = rx_bit_reg;
        rx_sh_next    = rx_sh_reg;
        rx_done_next  = 1'b0;
        case (rx_state_reg)
            RX_IDLE: begin
                rx_cnt_next = 16'h0000;
                if (ser_mode && !rx_line) begin
                    rx_state_next = RX_START;
                end
            end
            RX_START: begin
                if (rx_cnt_reg == HALF_LAST) begin
                    rx_cnt_next   = 16'h0000;
                    rx_bit_next   = 3'h0;
                    rx_state_next = rx_line ? RX_IDLE : RX_DATA;
                end
            end
            RX_DATA: begin
                if (rx_cnt_reg == BAUD_LAST) begin
                    rx_cnt_next = 16'h0000;
                    rx_sh_next  = {rx_line, rx_sh_reg[7:1]};
                    rx_bit_next = rx_bit_reg + 3'h1;
                    if (rx_bit_reg == 3'h7) begin
                        rx_state_next = RX_STOP;
                    end
                end
            end
            RX_STOP: begin
                if (rx_cnt_reg == BAUD_LAST) begin
                    rx_state_next = RX_IDLE;
                    rx_done_next  = rx_line;
                end
            end
            default: rx_state_next = RX_IDLE;
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            rx_state_reg <= RX_IDLE;
            rx_cnt_reg   <= 16'h0000;
            rx_bit_reg   <= 3'h0;
            rx_sh_reg    <= 8'h00;
            rx_done_reg  <= 1'b0;
        end else begin
            rx_state_reg <= rx_state_next;
            rx_cnt_reg   <= rx_cnt_next;
            rx_bit_reg   <= rx_bit_next;
            rx_sh_reg    <= rx_sh_next;
            rx_done_reg  <= rx_done_next;
        end
    end

    // ID check and serial command framing (op, address, data)
    logic [3:0]  id_idx_reg, id_idx_next;
    logic        id_bad_reg, id_bad_next, id_ok_reg, id_ok_next;
    logic [1:0]  fr_cnt_reg, fr_cnt_next;
    logic [1:0]  ser_op_reg, ser_op_next;
    logic [7:0]  ser_addr_reg, ser_addr_next, ser_data_reg, ser_data_next;
    logic        ser_req_reg, ser_req_next;
    logic        ack_push, id_last, id_match, ser_take;

    always_comb begin
        id_idx_next   = id_idx_reg;
        id_bad_next   = id_bad_reg;
        id_ok_next    = id_ok_reg;
        fr_cnt_next   = fr_cnt_reg;
        ser_op_next   = ser_op_reg;
        ser_addr_next = ser_addr_reg;
        ser_data_next = ser_data_reg;
        ser_req_next  = ser_req_reg & ~ser_take;
        id_match      = (rx_sh_reg == stored_id_in[32'(id_idx_reg) * 8 +: 8]);
        id_last       = (id_idx_reg == 4'(ID_BYTES - 1));
        ack_push      = rx_done_reg & ~id_ok_reg & id_last;
        if (rx_done_reg && !id_ok_reg) begin
            id_idx_next = id_last ? 4'h0 : id_idx_reg + 4'h1;
            id_bad_next = id_last ? 1'b0 : (id_bad_reg | ~id_match);
            id_ok_next  = id_last & ~id_bad_reg & id_match; // RQ1
        end else if (rx_done_reg && !ser_req_reg) begin
            fr_cnt_next = (fr_cnt_reg == 2'h2) ? 2'h0 : fr_cnt_reg + 2'h1;
            case (fr_cnt_reg)
                2'h0: ser_op_next = rx_sh_reg[1:0];
                2'h1: ser_addr_next = rx_sh_reg;
                default: begin
                    ser_data_next = rx_sh_reg;
                    ser_req_next  = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            id_idx_reg   <= 4'h0;
            id_bad_reg   <= 1'b0;
            id_ok_reg    <= 1'b0;
            fr_cnt_reg   <= 2'h0;
            ser_op_reg   <= 2'h0;
            ser_addr_reg <= 8'h00;
            ser_data_reg <= 8'h00;
            ser_req_reg  <= 1'b0;
        end else begin
            id_idx_reg   <= id_idx_next;
            id_bad_reg   <= id_bad_next;
            id_ok_reg    <= id_ok_next;
            fr_cnt_reg   <= fr_cnt_next;
            ser_op_reg   <= ser_op_next;
            ser_addr_reg <= ser_addr_next;
            ser_data_reg <= ser_data_next;
            ser_req_reg  <= ser_req_next;
        end
    end

    // Flash operation engine
    frm_eng_t          eng_reg, eng_next;
    logic [1:0]        op_reg, op_next;
    logic [ADDR_W-1:0] addr_reg, addr_next;
    logic [7:0]        data_reg, data_next;
    logic [15:0]       ab_cnt_reg, ab_cnt_next;
    logic              refused_reg, refused_next;
    logic              req_valid, eng_ready, accept, blocked, nmi_ack;
    logic [1:0]        req_op;
    logic [ADDR_W-1:0] req_addr;
    logic [7:0]        req_data;
    logic              fifo_in_ready, fifo_in_valid, fifo_out_valid, fifo_out_ready;
    logic [7:0]        fifo_in_data, fifo_out_data;

    always_comb begin
        case (mode)
            MODE_CPU: begin
                req_valid = cpu_valid_in;
                req_op    = cpu_op_in;
                req_addr  = cpu_addr_in;
                req_data  = cpu_data_in;
            end
            MODE_PARALLEL: begin
                req_valid = par_valid_in; // RQ4
                req_op    = par_op_in;
                req_addr  = par_addr_in;
                req_data  = par_data_in;
            end
            default: begin
                req_valid = ser_req_reg & id_ok_reg; // RQ1
                req_op    = ser_op_reg;
                req_addr  = ADDR_W'(ser_addr_reg);
                req_data  = ser_data_reg;
            end
        endcase
    end

    assign eng_ready     = (eng_reg == ENG_IDLE) & fifo_in_ready;
    assign accept        = req_valid & eng_ready;
    assign ser_take      = accept & ser_mode;
    assign blocked       = (mode == MODE_PARALLEL) & protect_active_in; // RQ5
    assign nmi_ack       = wdt_ack_in | osc_stop_ack_in | volt_mon_ack_in;
    assign par_ready_out = (mode == MODE_PARALLEL) & eng_ready;
    assign cpu_ready_out = (mode == MODE_CPU) & eng_ready;

    always_comb begin
        eng_next     = eng_reg;
        op_next      = op_reg;
        addr_next    = addr_reg;
        data_next    = data_reg;
        ab_cnt_next  = 16'h0000;
        refused_next = accept & blocked; // RQ5
        case (eng_reg)
            ENG_IDLE: begin
                if (accept && !blocked && req_op != OP_NONE) begin
                    eng_next  = ENG_BUSY; // RQ4
                    op_next   = req_op;
                    addr_next = req_addr;
                    data_next = req_data;
                end
            end
            ENG_BUSY: begin
                if (op_reg != OP_READ && nmi_ack) begin
                    eng_next = ENG_ABORT; // RQ9
                end else if (flash_done_in) begin
                    eng_next = ENG_IDLE;
                end
            end
            ENG_ABORT: begin
                ab_cnt_next = ab_cnt_reg + 16'h0001;
                if (ab_cnt_reg == ABORT_LAST) begin
                    eng_next = ENG_IDLE; // RQ10 RQ17
                end
            end
            default: eng_next = ENG_IDLE;
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            eng_reg     <= ENG_IDLE;
            op_reg      <= 2'h0;
            addr_reg    <= '0;
            data_reg    <= 8'h00;
            ab_cnt_reg  <= 16'h0000;
            refused_reg <= 1'b0;
        end else begin
            eng_reg     <= eng_next;
            op_reg      <= op_next;
            addr_reg    <= addr_next;
            data_reg    <= data_next;
            ab_cnt_reg  <= ab_cnt_next;
            refused_reg <= refused_next;
        end
    end

    assign flash_req_out   = (eng_reg == ENG_BUSY);
    assign flash_op_out    = op_reg;
    assign flash_addr_out  = addr_reg;
    assign flash_data_out  = data_reg;
    assign flash_reset_out = (eng_reg == ENG_ABORT); // RQ9
    assign irq_start_out   = (eng_reg == ENG_ABORT) & (ab_cnt_reg == ABORT_LAST); // RQ10
    assign refused_out     = refused_reg;
    assign id_ok_out       = id_ok_reg;
    // RAM-executed rewrite never holds off maskable interrupts
    assign mask_irq_grant_out = mask_irq_req_in & (ram_exec_rewrite_mode_in | (eng_reg != ENG_BUSY)); // RQ8

    // Read data and ID answers share one FIFO toward the serial or parallel side
    assign fifo_in_valid = ack_push | (flash_req_out & flash_done_in & (op_reg == OP_READ));
    assign fifo_in_data  = ack_push ? (id_ok_next ? `FRM_ACK_OK : `FRM_ACK_BAD) : flash_rdata_in;

    frm_fifo #(.W(8), .DEPTH(`FRM_FIFO_DEPTH)) u_fifo (
        .clk_in        (clk_in),
        .reset_in      (reset_in),
        .in_valid_in   (fifo_in_valid),
        .in_data_in    (fifo_in_data),
        .in_ready_out  (fifo_in_ready),
        .out_valid_out (fifo_out_valid),
        .out_data_out  (fifo_out_data),
        .out_ready_in  (fifo_out_ready)
    );

    assign fifo_out_ready = ser_mode ? ~tx_act_reg : rd_ready_in;
    assign rd_valid_out   = ~ser_mode & fifo_out_valid;
    assign rd_data_out    = fifo_out_data;

    // UART transmitter
    logic [9:0]  tx_sh_reg, tx_sh_next;
    logic [3:0]  tx_bits_reg, tx_bits_next;
    logic [15:0] tx_cnt_reg, tx_cnt_next;
    logic        tx_act_next;

    always_comb begin
        tx_sh_next   = tx_sh_reg;
        tx_bits_next = tx_bits_reg;
        tx_cnt_next  = tx_cnt_reg + 16'h0001;
        tx_act_next  = tx_act_reg;
        if (!tx_act_reg) begin
            tx_cnt_next = 16'h0000;
            if (ser_mode && fifo_out_valid) begin
                tx_sh_next   = {1'b1, fifo_out_data, 1'b0};
                tx_bits_next = 4'hA;
                tx_act_next  = 1'b1;
            end
        end else if (tx_cnt_reg == BAUD_LAST) begin
            tx_cnt_next  = 16'h0000;
            tx_sh_next   = {1'b1, tx_sh_reg[9:1]};
            tx_bits_next = tx_bits_reg - 4'h1;
            tx_act_next  = (tx_bits_reg != 4'h1);
        end
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            tx_sh_reg   <= 10'h3FF;
            tx_bits_reg <= 4'h0;
            tx_cnt_reg  <= 16'h0000;
            tx_act_reg  <= 1'b0;
        end else begin
            tx_sh_reg   <= tx_sh_next;
            tx_bits_reg <= tx_bits_next;
            tx_cnt_reg  <= tx_cnt_next;
            tx_act_reg  <= tx_act_next;
        end
    end

    assign txd_out         = (mode == MODE_SER_ASYNC) ? (tx_sh_reg[0] | ~tx_act_reg) : 1'b1; // RQ2
    assign mode_pin_out    = tx_sh_reg[0];
    assign mode_pin_oe_out = special & tx_act_reg; // RQ3

    AST_ID_GATE: assert property (@(posedge clk_in) disable iff (reset_in) // RQ1
        (flash_req_out && ser_mode) |-> id_ok_reg) else $error("serial flash access without ID match");
    AST_MODE2_NO_OE: assert property (@(posedge clk_in) disable iff (reset_in) // RQ2
        (mode == MODE_SER_ASYNC) |-> !mode_pin_oe_out) else $error("mode pin driven in mode 2");
    AST_MODE3_TXD_IDLE: assert property (@(posedge clk_in) disable iff (reset_in) // RQ3
        (tx_act_reg && special) |-> (txd_out && mode_pin_oe_out)) else $error("mode 3 transmit not on mode pin");
    AST_PAR_START: assert property (@(posedge clk_in) disable iff (reset_in) // RQ4
        (par_valid_in && par_ready_out && !protect_active_in && par_op_in != OP_NONE)
        |=> (flash_req_out && flash_op_out == $past(par_op_in) && flash_addr_out == $past(par_addr_in)))
        else $error("parallel command not started");
    AST_PROTECT: assert property (@(posedge clk_in) disable iff (reset_in) // RQ5
        (par_valid_in && par_ready_out && protect_active_in) |=> (refused_out && !flash_req_out))
        else $error("protected parallel access not refused");
    AST_MASKABLE: assert property (@(posedge clk_in) disable iff (reset_in) // RQ8
        (ram_exec_rewrite_mode_in && mask_irq_req_in) |-> mask_irq_grant_out) else $error("maskable irq held off");
    AST_ABORT: assert property (@(posedge clk_in) disable iff (reset_in) // RQ9
        (flash_req_out && flash_op_out != OP_READ && (wdt_ack_in || osc_stop_ack_in || volt_mon_ack_in))
        |=> (flash_reset_out && !flash_req_out)) else $error("rewrite not aborted");
    AST_ABORT_DELAY: assert property (@(posedge clk_in) disable iff (reset_in) // RQ10 RQ17
        $rose(flash_reset_out) |-> ##[ABORT_WAIT:ABORT_WAIT] (irq_start_out && flash_reset_out)
        ##1 (!flash_reset_out && !irq_start_out)) else $error("abort delay wrong");
endmodule : frm_ctrl
`default_nettype wire

// [tb/frm_flash_model.sv]
`timescale 1ns/1ps
`default_nettype none
module frm_flash_model (
    input  wire logic        clk_in,
    input  wire logic        req_in,
    input  wire logic [15:0] addr_in,
    input  var  int          lat_in,
    output logic             done_out,
    output logic [7:0]       rdata_out
);
    int   cnt = 0;
    logic served = 0;
    initial done_out = 0;
    // One done pulse per request after lat_in cycles
    always @(posedge clk_in) begin
        done_out <= 1'b0;
        if (!req_in) begin
            cnt <= 0;
            served <= 1'b0;
        end else if (!served && cnt >= lat_in) begin
            done_out <= 1'b1;
            served <= 1'b1;
        end else begin
            cnt <= cnt + 1;
        end
    end
    // Outside done the data bus shows the inverse
    assign rdata_out = done_out ? (addr_in[7:0] ^ 8'h5A) : ~(addr_in[7:0] ^ 8'h5A);
endmodule : frm_flash_model
`default_nettype wire

// [tb/frm_ctrl_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module frm_ctrl_tb_top import frm_pkg::*; ;
    localparam int BD = 8;
    localparam int AC = 3;
    localparam logic [55:0] SID = 56'h0123456789ABCD;
    typedef struct {logic [1:0] m, o; logic [7:0] a, d; logic p, er, ef;} frm_row_t;
    frm_row_t rows [8] = '{
        '{MODE_PARALLEL, OP_PROG, 8'h10, 8'hA5, 0, 1, 0}, '{MODE_PARALLEL, OP_ERASE, 8'h20, 8'h00, 0, 1, 0},
        '{MODE_PARALLEL, OP_READ, 8'h33, 8'h00, 0, 1, 0}, '{MODE_PARALLEL, OP_READ, 8'h44, 8'h00, 1, 0, 1},
        '{MODE_PARALLEL, OP_PROG, 8'h45, 8'h3C, 1, 0, 1}, '{MODE_CPU, OP_ERASE, 8'h60, 8'h00, 0, 1, 0},
        '{MODE_CPU, OP_READ, 8'h7E, 8'h00, 0, 1, 0}, '{MODE_PARALLEL, OP_NONE, 8'h12, 8'h00, 0, 0, 0}};
    logic clk_in = 0, reset_in = 1, prot = 0, rxd = 1, pin_drv = 1, pv = 0, cv = 0, ram = 0, mreq = 0, rd_rdy = 1;
    logic [2:0]  ack = 0;
    logic [1:0]  mode = MODE_PARALLEL, op = 0, fop;
    logic [15:0] addr = 0, fad;
    logic [7:0]  data = 0, b, rdd, fdat, frd;
    logic txd, pin_o, oe, pr, cr, rdv, idok, refd, freq, frst, done, irq, grant;
    int fail_count = 0, check_count = 0, lat = 4, n, k;
    // Mode pin is shared: the device wins while its enable is high
    wire logic pin = oe ? pin_o : pin_drv;
    wire logic line = (mode == MODE_SER_ASYNC) ? txd : pin;
    always #5 clk_in = ~clk_in;
    frm_ctrl #(.BAUD_DIV(BD), .ABORT_CYCLES(AC)) frm_ctrl_inst (
        .clk_in(clk_in), .reset_in(reset_in), .prog_mode_in(mode), .stored_id_in(SID),
        .protect_active_in(prot), .rxd_in(rxd), .txd_out(txd), .mode_pin_in(pin), .mode_pin_out(pin_o),
        .mode_pin_oe_out(oe), .par_valid_in(pv), .par_op_in(op), .par_addr_in(addr), .par_data_in(data),
        .par_ready_out(pr), .cpu_valid_in(cv), .cpu_op_in(op), .cpu_addr_in(addr), .cpu_data_in(data),
        .cpu_ready_out(cr), .rd_valid_out(rdv), .rd_data_out(rdd), .rd_ready_in(rd_rdy), .id_ok_out(idok),
        .refused_out(refd), .flash_req_out(freq), .flash_op_out(fop), .flash_addr_out(fad),
        .flash_data_out(fdat), .flash_done_in(done), .flash_rdata_in(frd), .flash_reset_out(frst),
        .ram_exec_rewrite_mode_in(ram), .wdt_ack_in(ack[2]), .osc_stop_ack_in(ack[1]),
        .volt_mon_ack_in(ack[0]), .irq_start_out(irq), .mask_irq_req_in(mreq), .mask_irq_grant_out(grant));
    frm_flash_model frm_flash_model_inst (.clk_in(clk_in), .req_in(freq), .addr_in(fad), .lat_in(lat),
        .done_out(done), .rdata_out(frd));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic complete_run;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : complete_run
    task automatic cmd(input frm_row_t r);
        {mode, op, addr, data, prot, ram} = {r.m, r.o, 8'h00, r.a, r.d, r.p, r.m == MODE_CPU};
        {pv, cv, mreq, n} = {r.m == MODE_PARALLEL, r.m == MODE_CPU, r.m == MODE_CPU, 32'h0};
        while ((pv ? pr : cr) !== 1'b1 && n < 50) begin
            @(posedge clk_in);
            #1 n++;
        end
        @(posedge clk_in);
        #1 {pv, cv} = 2'h0;
        chk({freq, refd}, {r.er, r.ef});
        if (r.er)
            chk({fop, fad, fdat, grant}, {r.o, 8'h00, r.a, r.d, ram});
        if (lat < 50) begin
            while (freq === 1'b1 && n < 200) begin
                @(posedge clk_in);
                #1 n++;
            end
            @(posedge clk_in);
            #1;
            if (r.o == OP_READ && rd_rdy && r.er)
                chk({rdv, rdd}, {1'b1, r.a ^ 8'h5A});
        end
    endtask : cmd
    task automatic ser_tx(input logic [7:0] v);
        logic [8:0] f;
        f = {v, 1'b0};
        for (int i = 0; i < 10; i++) begin
            {rxd, pin_drv} = {2{(i == 9) | f[i % 9]}};
            repeat (BD) @(posedge clk_in);
            #1;
        end
    endtask : ser_tx
    task automatic ser_rx(output logic [7:0] v);
        n = 0;
        while (line !== 1'b0 && n < 400) begin
            @(posedge clk_in);
            #1 n++;
        end
        repeat (BD / 2) @(posedge clk_in);
        chk(oe, mode == MODE_SER_SPECIAL);
        for (int i = 0; i < 8; i++) begin
            repeat (BD) @(posedge clk_in);
            v[i] = line;
        end
        repeat (BD + BD / 2) @(posedge clk_in);
        #1;
    endtask : ser_rx
    initial begin
        #400000;
        fail_count++;
        complete_run();
    end
    initial begin
        repeat (16) @(posedge clk_in);
        #1 reset_in = 0;
        chk({freq, frst, irq, txd, oe, rdv, refd, idok}, 8'h10);
        $display("test reset done");
        foreach (rows[i]) begin
            lat = 1 + 5 * i;
            cmd(rows[i]);
        end
        $display("test commands done");
        {lat, rd_rdy} = {32'h1, 1'b0};
        for (k = 0; k < 20 && pr === 1'b1; k++)
            cmd('{MODE_PARALLEL, OP_READ, k[7:0], 8'h00, 0, 1, 0});
        chk({pr, 8'(k)}, {1'b0, 8'h11});
        rd_rdy = 1;
        for (k = 0; k < 17; k++) begin
            for (n = 0; rdv !== 1'b1 && n < 10; n++)
                @(posedge clk_in);
            #1 chk({rdv, rdd}, {1'b1, k[7:0] ^ 8'h5A});
            @(posedge clk_in);
        end
        #1 chk(rdv, 0);
        $display("test buffer done");
        lat = 100;
        for (k = 0; k < 3; k++) begin
            cmd('{MODE_PARALLEL, k[0] ? OP_PROG : OP_ERASE, 8'h50, 8'h00, 0, 1, 0});
            repeat (5) @(posedge clk_in);
            #1 ack = 3'h4 >> k;
            @(posedge clk_in);
            #1 ack = 3'h0;
            for (int j = 1; j <= AC; j++) begin
                chk({freq, frst, irq}, {2'b01, j == AC});
                @(posedge clk_in);
                #1;
            end
            chk({frst, irq, pr}, 3'h1);
        end
        lat = 2;
        cmd('{MODE_PARALLEL, OP_ERASE, 8'h50, 8'h00, 0, 1, 0});
        $display("test abort done");
        for (k = 0; k < 2; k++) begin
            {mode, lat, reset_in} = {k[0] ? MODE_SER_SPECIAL : MODE_SER_ASYNC, 32'h2, 1'b1};
            repeat (4) @(posedge clk_in);
            #1 reset_in = 0;
            for (int i = 0; i < 14; i++) begin
                ser_tx(SID[8 * (i % 7) +: 8] ^ ((i < 7) ? 8'h01 : 8'h00));
                if (i % 7 == 6) begin
                    ser_rx(b);
                    chk({b, idok}, {(i < 7) ? 8'h15 : 8'h06, i > 7});
                end
            end
            ser_tx(8'h01);
            ser_tx(8'h21);
            ser_tx(8'h00);
            ser_rx(b);
            chk(b, 8'h21 ^ 8'h5A);
        end
        $display("test serial done");
        complete_run();
    end
endmodule : frm_ctrl_tb_top
`default_nettype wire
